// ### hw/bcfc_pkg.sv
// bcfc_pkg: shared constants and carrier types for the brushless
// commutation and fault control block.
// assumes a single 50 MHz clock and synchronous inputs.
//
// Notes on behaviour
// - three hall inputs decode into six bridge drives, three upper three lower
// - overcurrent sets a latch holding all switches off until ramp cycle ends
// - any of three undervoltage indications forces all drive off
// - invalid hall code or over-temperature also forces all drive off
// - active-low fault output is low while any fault is present
// - pwm is duty (demand in open loop) compared against ramp; any fault overrides pwm
// - decoder supports 60 and 120 degree hall spacing via config input
// - fixed configurable pulse on every edge of each hall input
// - duty widens when speed below demand, narrows when above
// - no braking; zero duty leaves all lower drive off so motor coasts
package bcfc_pkg;

  // ----------------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------------
  localparam int RAMP_W          = 11;
  localparam logic [10:0] RAMP_TOP = 11'h7ff;  // last ramp count; ramp period is 2048 cycles
  localparam int TACH_W          = 16;
  // default tach pulse: 950 us at 50 MHz
  localparam int TACH_US         = 950;
  localparam int CLK_MHZ         = 50;
  localparam int TACH_CYC        = TACH_US * CLK_MHZ;
  localparam int SPEED_W         = 16;
  // speed window is 2**WIN_W ramp periods
  localparam int WIN_W           = 8;
  localparam logic [10:0] DUTY_RST = 11'h000;  // duty after reset
  localparam logic [15:0] SPEED_RST = 16'h0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] upper;
    logic [2:0] lower;
  } bcfc_drive_t;

  typedef struct packed {
    logic uv_logic;
    logic uv_gate;
    logic uv_ref;
    logic over_temp;
    logic over_current;
  } bcfc_fault_t;

endpackage

// ### hw/bcfc_decode.sv
// bcfc_decode: combinational hall to six-step conduction decoder.
// assumes hall inputs already synchronous to the clock.
`timescale 1ns/10ps
module bcfc_decode (
  // hall and mode
  input  wire logic              i_hall_a,
  input  wire logic              i_hall_b,
  input  wire logic              i_hall_c,
  input  wire logic              i_sixty,
  input  wire logic              i_reverse,
  // result
  output bcfc_pkg::bcfc_drive_t  o_drive,
  output logic                   o_invalid
);

  logic [2:0] code;
  logic [2:0] step;

  // ----------------------------------------------------------------
  // hall code to step index
  // ----------------------------------------------------------------
  // sixty degree spacing is mapped by inverting the middle sensor,
  // which turns its code set into the 120 degree set
  always_comb begin
    code      = {i_hall_c, i_sixty ^ i_hall_b, i_hall_a};
    step      = 3'h0;
    o_invalid = 1'b0;
    case (code)
      3'h1:    step = 3'h0;
      3'h3:    step = 3'h1;
      3'h2:    step = 3'h2;
      3'h6:    step = 3'h3;
      3'h4:    step = 3'h4;
      3'h5:    step = 3'h5;
      default: o_invalid = 1'b1;  // 000 or 111
    endcase
    // reversal shifts the pattern by three steps
    if (i_reverse) begin
      step = (step >= 3'h3) ? step - 3'h3 : step + 3'h3;
    end
  end

  // ----------------------------------------------------------------
  // step to one upper and one lower leg
  // ----------------------------------------------------------------
  always_comb begin
    o_drive = '0;
    if (!o_invalid) begin
      case (step)
        3'h0:    o_drive = {3'h1, 3'h2};
        3'h1:    o_drive = {3'h1, 3'h4};
        3'h2:    o_drive = {3'h2, 3'h4};
        3'h3:    o_drive = {3'h2, 3'h1};
        3'h4:    o_drive = {3'h4, 3'h1};
        3'h5:    o_drive = {3'h4, 3'h2};
        default: o_drive = '0;
      endcase
    end
  end

endmodule

// ### hw/bcfc_tach.sv
// bcfc_tach: fixed-width pulse on every hall edge for speed sensing.
// assumes hall inputs synchronous to the clock.
`timescale 1ns/10ps
module bcfc_tach #(
  parameter int TACH_W = 16
) (
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_srst,
  // hall and width
  input  wire logic [2:0]        i_hall,
  input  wire logic [TACH_W-1:0] i_width,
  // pulse out
  output logic                   o_pulse,
  output logic                   o_edge
);

  logic [2:0]        hall_q;
  logic [2:0]        next_hall_q;
  logic [TACH_W-1:0] count;
  logic [TACH_W-1:0] next_count;
  logic              next_pulse;
  logic              next_edge;

  // ----------------------------------------------------------------
  // edge detect and one-shot
  // ----------------------------------------------------------------
  // an edge inside a running pulse retriggers it, so pulses merge
  // when speed exceeds what the chosen width allows
  always_comb begin
    next_hall_q = i_hall;
    next_edge   = |(i_hall ^ hall_q);  // both edges
    next_count  = count;
    if (next_edge && i_width != '0) begin
      next_count = i_width;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
    next_pulse = (next_count != '0);
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      hall_q  <= i_hall;  // start at pin level: no false edge on release
      count   <= '0;
      o_pulse <= 1'b0;
      o_edge  <= 1'b0;
    end else begin
      hall_q  <= next_hall_q;
      count   <= next_count;
      o_pulse <= next_pulse;
      o_edge  <= next_edge;
    end
  end

endmodule

// ### hw/bcfc_top.sv
// bcfc_top: brushless commutation, pwm, speed loop and fault shutdown.
// assumes all inputs synchronous to I_CLOCK; comparator and supply
// monitors arrive as logic levels, active high unless named _n.
`timescale 1ns/10ps
module bcfc_top #(
  parameter int RAMP_W  = bcfc_pkg::RAMP_W,
  parameter int TACH_W  = bcfc_pkg::TACH_W,
  parameter int SPEED_W = bcfc_pkg::SPEED_W,
  parameter int WIN_W   = bcfc_pkg::WIN_W
) (
  // clock and reset
  input  wire logic               I_CLOCK,
  input  wire logic               I_SRST,
  // hall sensors and mode
  input  wire logic [2:0]         I_HALL,
  input  wire logic               I_SIXTY_DEG,
  input  wire logic               I_REVERSE,
  // speed demand and loop mode
  input  wire logic [RAMP_W-1:0]  I_DEMAND,
  input  wire logic               I_CLOSED_LOOP,
  input  wire logic [SPEED_W-1:0] I_SPEED_DEMAND,
  input  wire logic [TACH_W-1:0]  I_TACH_WIDTH,
  // fault sources
  input  wire logic               I_OVER_CURRENT,
  input  wire logic               I_UV_LOGIC,
  input  wire logic               I_UV_GATE,
  input  wire logic               I_UV_REF,
  input  wire logic               I_OVER_TEMP,
  // bridge drive
  output logic [2:0]              O_UPPER,
  output logic [2:0]              O_LOWER,
  // status
  output logic                    O_FAULT_N,
  output logic                    O_TACH,
  output logic                    O_PWM
);

  // ----------------------------------------------------------------
  // commutation decode
  // ----------------------------------------------------------------
  bcfc_pkg::bcfc_drive_t drive;
  logic                  hall_bad;

  bcfc_decode u_decode (
    .i_hall_a  (I_HALL[0]),
    .i_hall_b  (I_HALL[1]),
    .i_hall_c  (I_HALL[2]),
    .i_sixty   (I_SIXTY_DEG),
    .i_reverse (I_REVERSE),
    .o_drive   (drive),
    .o_invalid (hall_bad)
  );

  // ----------------------------------------------------------------
  // speed pulse
  // ----------------------------------------------------------------
  logic tach;
  logic hall_edge;

  bcfc_tach #(
    .TACH_W (TACH_W)
  ) u_tach (
    .i_clock (I_CLOCK),
    .i_srst  (I_SRST),
    .i_hall  (I_HALL),
    .i_width (I_TACH_WIDTH),
    .o_pulse (tach),
    .o_edge  (hall_edge)
  );

  // ----------------------------------------------------------------
  // ramp oscillator and speed measurement
  // ----------------------------------------------------------------
  // speed is the tach high-cycle count per ramp window, a digital
  // stand-in for the low-pass filtered pulse train
  logic [RAMP_W-1:0]  ramp;
  logic [RAMP_W-1:0]  next_ramp;
  logic               cycle_end;
  logic [SPEED_W-1:0] acc;
  logic [SPEED_W-1:0] next_acc;
  logic [SPEED_W-1:0] speed;
  logic [SPEED_W-1:0] next_speed;
  logic [WIN_W-1:0]   win;
  logic [WIN_W-1:0]   next_win;

  always_comb begin
    cycle_end  = (ramp == RAMP_W'(bcfc_pkg::RAMP_TOP));
    next_ramp  = cycle_end ? '0 : ramp + 1'b1;
    next_acc   = acc;
    next_speed = speed;
    next_win   = win;
    if (tach && acc != '1) begin
      next_acc = acc + 1'b1;
    end
    // measure over 2**WIN_W ramp cycles for a steady reading
    if (cycle_end) begin
      next_win = win + 1'b1;
      if (win == '1) begin
        next_speed = next_acc;
        next_acc   = '0;
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      ramp  <= '0;
      acc   <= '0;
      speed <= bcfc_pkg::SPEED_RST;
      win   <= '0;
    end else begin
      ramp  <= next_ramp;
      acc   <= next_acc;
      speed <= next_speed;
      win   <= next_win;
    end
  end

  // ----------------------------------------------------------------
  // duty regulation
  // ----------------------------------------------------------------
  // closed loop steps duty by one per window; slow but it cannot
  // overshoot hard, and there is no braking to correct an overshoot
  logic [RAMP_W-1:0] duty;
  logic [RAMP_W-1:0] next_duty;

  always_comb begin
    next_duty = duty;
    if (!I_CLOSED_LOOP) begin
      next_duty = I_DEMAND;
    end else if (cycle_end && win == '1) begin
      if (next_speed < I_SPEED_DEMAND && duty != '1) begin
        next_duty = duty + 1'b1;
      end else if (next_speed > I_SPEED_DEMAND && duty != '0) begin
        next_duty = duty - 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      duty <= RAMP_W'(bcfc_pkg::DUTY_RST);
    end else begin
      duty <= next_duty;
    end
  end

  // ----------------------------------------------------------------
  // overcurrent latch
  // ----------------------------------------------------------------
  // set wins over the end-of-cycle clear so a trip is never missed
  logic oc_latch;
  logic next_oc_latch;

  always_comb begin
    next_oc_latch = oc_latch;
    if (I_OVER_CURRENT) begin
      next_oc_latch = 1'b1;
    end else if (cycle_end) begin
      next_oc_latch = 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      oc_latch <= 1'b0;
    end else begin
      oc_latch <= next_oc_latch;
    end
  end

  // ----------------------------------------------------------------
  // fault gathering and drive outputs
  // ----------------------------------------------------------------
  bcfc_pkg::bcfc_fault_t faults;
  logic                  any_fault;
  logic                  pwm;
  logic [2:0]            next_upper;
  logic [2:0]            next_lower;
  logic                  next_fault_n;
  logic                  next_pwm;

  always_comb begin
    faults.uv_logic     = I_UV_LOGIC;
    faults.uv_gate      = I_UV_GATE;
    faults.uv_ref       = I_UV_REF;
    faults.over_temp    = I_OVER_TEMP;
    faults.over_current = next_oc_latch;
    any_fault    = (|faults) | hall_bad;
    pwm          = (ramp < duty);        // zero duty never on
    next_pwm     = pwm & ~any_fault;
    next_fault_n = ~any_fault;
    next_upper   = 3'h0;
    next_lower   = 3'h0;
    // lower legs chopped by pwm; upper legs held for the step
    if (!any_fault) begin
      next_upper = drive.upper;
      next_lower = pwm ? drive.lower : 3'h0;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      O_UPPER   <= 3'h0;
      O_LOWER   <= 3'h0;
      O_FAULT_N <= 1'b1;
      O_PWM     <= 1'b0;
      O_TACH    <= 1'b0;
    end else begin
      O_UPPER   <= next_upper;
      O_LOWER   <= next_lower;
      O_FAULT_N <= next_fault_n;
      O_PWM     <= next_pwm;
      O_TACH    <= tach;
    end
  end

  // hall_edge is exported by the tach for debugging only
  logic unused_edge;
  assign unused_edge = hall_edge;

endmodule

// ### test/bcfc_hall_model.sv
// bcfc_hall_model: three hall sensors seen from the motor side.
// assumes the bench picks the rotor step; levels are combinational.
`timescale 1ns/10ps
module bcfc_hall_model (
  // rotor position and mounting
  input  wire logic [2:0] i_idx,
  input  wire logic       i_sixty,
  input  wire logic       i_bad,
  // sensor levels, [0]=a [2]=c
  output logic [2:0]      o_hall
);
  // six-step order, one sensor flips per step
  localparam logic [17:0] SEQ = {3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  // 60 degree mounting shows sensor b inverted; bad gives a code that
  // decodes to 000 or 111 in either mounting
  always_comb begin
    o_hall = SEQ[i_idx*3 +: 3] ^ {1'b0, i_sixty, 1'b0};
    if (i_bad) begin
      o_hall = (i_idx[0] ? 3'h7 : 3'h0) ^ {1'b0, i_sixty, 1'b0};
    end
  end
endmodule

// ### test/bcfc_checker.sv
// bcfc_checker: port-level properties of bcfc_top.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module bcfc_checker #(
  parameter int RAMP_W = 11,
  parameter int TACH_W = 16
) (
  // watched ports
  input wire logic              I_CLOCK,
  input wire logic              I_SRST,
  input wire logic [2:0]        I_HALL,
  input wire logic              I_SIXTY_DEG,
  input wire logic [RAMP_W-1:0] I_DEMAND,
  input wire logic              I_CLOSED_LOOP,
  input wire logic [TACH_W-1:0] I_TACH_WIDTH,
  input wire logic              I_OVER_CURRENT,
  input wire logic              I_UV_LOGIC,
  input wire logic              I_UV_GATE,
  input wire logic              I_UV_REF,
  input wire logic              I_OVER_TEMP,
  input wire logic [2:0]        O_UPPER,
  input wire logic [2:0]        O_LOWER,
  input wire logic              O_FAULT_N,
  input wire logic              O_TACH,
  input wire logic              O_PWM
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);
  // all six switches open
  wire logic off = ~|{O_UPPER, O_LOWER};
  property p_uv;
    I_UV_LOGIC || I_UV_GATE || I_UV_REF |=> off && !O_FAULT_N;
  endproperty
  a_uv: assert property (p_uv)
    else $error("drive on in undervoltage");
  property p_temp;
    I_OVER_TEMP |=> off && !O_FAULT_N;
  endproperty
  a_temp: assert property (p_temp)
    else $error("drive on when hot");
  // 60 degree mounting inverts sensor b, so judge the decoded code
  property p_inv;
    {I_HALL[2], I_HALL[1] ^ I_SIXTY_DEG, I_HALL[0]} inside {3'h0, 3'h7}
      |=> off && !O_FAULT_N;
  endproperty
  a_inv: assert property (p_inv)
    else $error("drive on bad hall");
  // the latch must outlast the trip by at least its own set cycle
  property p_oc;
    I_OVER_CURRENT |=> (off && !O_PWM && !O_FAULT_N) [*2];
  endproperty
  a_oc: assert property (p_oc)
    else $error("overcurrent not latched");
  property p_one;
    |O_UPPER |-> $onehot(O_UPPER) && $onehot0(O_LOWER)
      && !(|(O_UPPER & O_LOWER));
  endproperty
  a_one: assert property (p_one)
    else $error("bad conduction pair");
  property p_pwm;
    |O_LOWER |-> O_PWM && O_FAULT_N;
  endproperty
  a_pwm: assert property (p_pwm)
    else $error("lower on without pwm");
  property p_tach;
    $changed(I_HALL) && I_TACH_WIDTH != 0 |-> ##2 O_TACH;
  endproperty
  a_tach: assert property (p_tach)
    else $error("no tach pulse");
  property p_coast;
    (!I_CLOSED_LOOP && I_DEMAND == 0) [*3] |=> !(|O_LOWER) && !O_PWM;
  endproperty
  a_coast: assert property (p_coast)
    else $error("drive at zero duty");
  c_edge: cover property ($changed(I_HALL));
  c_oc: cover property (I_OVER_CURRENT);
  c_low: cover property (|O_LOWER);
endmodule
bind bcfc_top bcfc_checker #(.RAMP_W(RAMP_W), .TACH_W(TACH_W))
  u_bcfc_checker (.*);

// ### test/brushless_commutation_fault_control_tb.sv
// brushless_commutation_fault_control_tb: table of steps, then faults,
// duty, overcurrent latch, closed loop and tach. assumes 50 MHz,
// tach width 5 and a speed window of two ramp periods.
`timescale 1ns/10ps
module brushless_commutation_fault_control_tb;
  typedef struct packed {
    logic [2:0] idx;
    logic [1:0] up;
    logic [1:0] lo;
  } bcfc_row_t;
  // step in, expected upper and lower leg out
  bcfc_row_t rows [6] = '{'{0,0,1}, '{1,0,2}, '{2,1,2},
                         '{3,1,0}, '{4,2,0}, '{5,2,1}};
  bcfc_row_t e;
  logic clk = 0, srst = 1, sixty = 0, rev = 0, bad = 0;
  logic [2:0] idx = 0, hall, up, lo, lo2;
  logic [10:0] dem = 11'h7ff;
  logic cl = 0;
  logic [15:0] sdem = 16'h0000;
  int cnt [4];
  bcfc_pkg::bcfc_fault_t flt = '0;
  logic fault_n, tach, pwm;
  int error_cnt = 0, samples_checked = 0, n, t;
  always #10 clk = ~clk;
  bcfc_hall_model u_bcfc_hall_model (.i_idx(idx), .i_sixty(sixty),
    .i_bad(bad), .o_hall(hall));
  // a short speed window lets closed loop steps show in a short run
  bcfc_top #(.WIN_W(1)) u_bcfc_top (.I_CLOCK(clk), .I_SRST(srst),
    .I_HALL(hall), .I_SIXTY_DEG(sixty), .I_REVERSE(rev), .I_DEMAND(dem),
    .I_CLOSED_LOOP(cl), .I_SPEED_DEMAND(sdem),
    .I_TACH_WIDTH(16'h0005), .I_OVER_CURRENT(flt.over_current),
    .I_UV_LOGIC(flt.uv_logic), .I_UV_GATE(flt.uv_gate),
    .I_UV_REF(flt.uv_ref), .I_OVER_TEMP(flt.over_temp),
    .O_UPPER(up), .O_LOWER(lo), .O_FAULT_N(fault_n), .O_TACH(tach),
    .O_PWM(pwm));
  task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog well beyond the ~30k cycles the tests need
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (9) @(posedge clk);
    #1 check("reset", {up, lo, fault_n, tach, pwm}, 12'h004);
    @(posedge clk) srst <= 1'b0;
    // every step in both spacings and both directions
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 6; k++) begin
        @(posedge clk);
        sixty <= m[0];
        rev <= m[1];
        idx <= rows[k].idx;
        repeat (3) @(posedge clk);
        #1 e = rows[(k + 3 * m[1]) % 6];
        lo2 = lo;
        check("upper", up, 12'h1 << e.up);
        @(posedge clk);
        #1 check("lower", lo | lo2, 12'h1 << e.lo);
      end
    end
    $display("step table done");
    // each unlatched fault source, then an invalid hall code
    for (int f = 0; f < 5; f++) begin
      @(posedge clk);
      if (f < 4) flt <= 5'h10 >> f;
      else bad <= 1'b1;
      repeat (2) @(posedge clk);
      #1 check("drive", {up, lo, pwm}, 12'h0);
      check("fault_n", fault_n, 12'h0);
      @(posedge clk);
      flt <= '0;
      bad <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check("fault_n", fault_n, 12'h1);
    end
    $display("faults done");
    // lower count over one full ramp equals the demanded duty
    foreach (rows[d]) if (d < 3) begin
      @(posedge clk) dem <= (d == 0) ? 11'h000 : (d == 1) ? 11'h400 : 11'h7ff;
      repeat (4) @(posedge clk);
      n = 0;
      t = 0;
      repeat (2048) @(posedge clk) begin
        n += pwm;
        t += |lo;
      end
      check("pwm count", n[11:0], {1'b0, dem});
      check("lower count", t[11:0], {1'b0, dem});
    end
    $display("duty done");
    // trip right after the ramp restarts so the cycle end is far away
    dem <= 11'h400;
    @(posedge pwm);
    @(posedge clk) flt <= 5'h01;
    @(posedge clk) flt <= '0;
    repeat (1000) @(posedge clk);
    #1 check("latched", {fault_n, up, lo}, 12'h0);
    n = 0;
    while (!fault_n && n < 1200) @(posedge clk) n++;
    #1 check("oc release", fault_n, 12'h1);
    $display("overcurrent done");
    // closed loop: one ramp period per block; exactly one window end
    // falls between blocks 1 and 3, so duty moves by exactly one
    @(posedge clk);
    cl <= 1'b1;
    sdem <= 16'h0001;
    t = 0;
    for (int s = 0; s < 2; s++) begin
      @(posedge pwm);
      for (int b = 0; b < 4; b++) begin
        cnt[b] = 0;
        repeat (2048) @(posedge clk) begin
          cnt[b] += pwm;
          t++;
          // stepping halls give a nonzero speed, above a zero demand
          if (s == 1 && t % 128 == 0) idx <= 3'((int'(idx) + 1) % 6);
        end
      end
      // idle halls read speed 0 below demand 1: widen; then narrow
      check("closed loop", 12'(cnt[3]), 12'(cnt[1] + 1 - 2 * s));
      sdem <= 16'h0000;
    end
    cl <= 1'b0;
    idx <= 3'h0;
    // let the last tach pulse die out before counting pulses
    repeat (20) @(posedge clk);
    $display("closed loop done");
    // six steps touch a rising and falling edge of every sensor
    n = 0;
    for (int k = 1; k < 7; k++) begin
      @(posedge clk) idx <= 3'(k % 6);
      repeat (10) @(posedge clk) n += tach;
    end
    check("tach cycles", n[11:0], 12'd30);
    $display("tach done");
    give_verdict();
  end
endmodule
